// ---- test_thermal_head_shift_latch_driver.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_thermal_head_shift_latch_driver;
  logic        clk, rst_n, en_lo_n, en_hi, sen, sdat, stb, so;
  logic [11:0] pin, oe_n, hl, w;
  logic [31:0] rng;
  logic        sq[$];
  int          mismatches, n_checks;
  thd_head_driver DUT (.CLOCK_I(clk), .RST_N_I(rst_n), .SHIFT_EN_I(sen), .SERIAL_I(sdat),
    .LATCH_STROBE_I(stb), .OUTPUT_ENABLE_ACTIVE_LOW_N_I(en_lo_n), .OUTPUT_ENABLE_ACTIVE_HIGH_I(en_hi),
    .SERIAL_O(so), .HEAD_DRIVER_OUTPUT_O(pin), .HEAD_DRIVER_OUTPUT_OE_N_O(oe_n));
  thd_printer_model PRT (.clk_i(clk), .shift_en_o(sen), .serial_o(sdat), .strobe_o(stb));
  // 50 MHz clock
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // Xorshift source
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (mismatches == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  // Random words: shift, latch, sweep enables
  initial begin
    mismatches = 0;
    n_checks   = 0;
    rng        = 32'h34;
    hl         = 12'h000;
    rst_n      = 1'h0;
    en_lo_n    = 1'h0;
    en_hi      = 1'h1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst_n = 1'h1;
    #1;
    chk("oe_n_reset", 12'hfff, oe_n);
    for (int k = 0; k < 8; k++) begin
      rng = xs(rng);
      w   = rng[11:0];
      PRT.send(w);
      for (int i = 11; i >= 0; i--) begin
        sq.push_back(w[i]);
      end
      chk("serial_out", {11'h000, sq[sq.size()-12]}, {11'h000, so});
      chk("oe_n_kept", ~hl, oe_n);
      PRT.strobe();
      for (int j = 0; j < 12; j++) begin
        hl[j] = sq[sq.size()-1-j];
      end
      for (int e = 0; e < 4; e++) begin
        @(negedge clk);
        en_lo_n = e[0];
        en_hi   = e[1];
        #1;
        chk("oe_n", (e == 2) ? ~hl : 12'hfff, oe_n);
      end
      chk("pin_level", 12'h000, pin);
      en_lo_n = 1'h0;
      en_hi   = 1'h1;
    end
    tally_and_finish();
  end
endmodule : test_thermal_head_shift_latch_driver
`default_nettype wire

// ---- thd_driver_stage.sv ----
`timescale 1ns/1ns
`default_nettype none
// Open-drain gating of the latched bits onto the driver pins
module thd_driver_stage (
  input  wire logic [thd_pkg::STAGES-1:0] held_i,     // Latched print bits
  input  wire logic                       en_low_n_i, // Active-low enable
  input  wire logic                       en_high_i,  // Active-high enable
  output logic      [thd_pkg::STAGES-1:0] pin_o,      // Pin output level
  output logic      [thd_pkg::STAGES-1:0] pin_oe_n_o  // Low while sinking
);
  ////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < thd_pkg::STAGES; g++) begin : g_drv
      assign pin_o[g] = thd_pkg::SINK_LEVEL;
      assign pin_oe_n_o[g] = ~(held_i[g] & ~en_low_n_i & en_high_i);
    end
  endgenerate
endmodule : thd_driver_stage
`default_nettype wire

// ---- thd_head_driver.sv ----
`timescale 1ns/1ns
`default_nettype none
// Serial-in, latched, open-drain thermal head driver
module thd_head_driver (
  input  wire logic                       CLOCK_I,                      // Shift clock domain
  input  wire logic                       RST_N_I,                      // Sync reset, active low
  input  wire logic                       SHIFT_EN_I,                   // Shift one bit this cycle
  input  wire logic                       SERIAL_I,                     // Serial print data
  input  wire logic                       LATCH_STROBE_I,               // Latch strobe
  input  wire logic                       OUTPUT_ENABLE_ACTIVE_LOW_N_I, // Enable, active low
  input  wire logic                       OUTPUT_ENABLE_ACTIVE_HIGH_I,  // Enable, active high
  output logic                            SERIAL_O,                     // Cascade output
  output logic      [thd_pkg::STAGES-1:0] HEAD_DRIVER_OUTPUT_O,         // Pin level
  output logic      [thd_pkg::STAGES-1:0] HEAD_DRIVER_OUTPUT_OE_N_O     // Low while sinking
);
  ////////////////////////////////////////////////////////////////////////
  // State
  logic [thd_pkg::STAGES-1:0] shift_r, shift_nxt;   // Shift register
  logic [thd_pkg::STAGES-1:0] hold_r, hold_nxt;     // Holding latch
  logic                       strobe_r, strobe_nxt; // Previous strobe level
  logic                       strobe_fall;          // Falling strobe edge

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    // Edge detect against the last sampled strobe level
    strobe_fall = strobe_r & ~LATCH_STROBE_I;
    strobe_nxt  = LATCH_STROBE_I;
    if (SHIFT_EN_I) begin
      // New bit enters stage 0, last stage bit moves out
      shift_nxt = {shift_r[thd_pkg::STAGES-2:0], SERIAL_I};
    end else begin
      // No shift pulse, register rests
      shift_nxt = shift_r;
    end
    if (strobe_fall) begin
      // Pre-shift contents win over a same-edge shift
      hold_nxt = shift_r;
    end else begin
      // Latch keeps the line being printed
      hold_nxt = hold_r;
    end
  end

  // Registers
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      // Clear data, strobe history at its idle level
      shift_r  <= thd_pkg::CLEAR_VALUE;
      hold_r   <= thd_pkg::CLEAR_VALUE;
      strobe_r <= thd_pkg::STROBE_IDLE;
    end else begin
      // Take the next values
      shift_r  <= shift_nxt;
      hold_r   <= hold_nxt;
      strobe_r <= strobe_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // last stage out
  // Cascade pin reads the last stage flip-flop directly, no extra delay
  assign SERIAL_O = shift_r[thd_pkg::STAGES-1];

  // Output stage
  thd_driver_stage u_drv (
    .held_i     (hold_r),
    .en_low_n_i (OUTPUT_ENABLE_ACTIVE_LOW_N_I),
    .en_high_i  (OUTPUT_ENABLE_ACTIVE_HIGH_I),
    .pin_o      (HEAD_DRIVER_OUTPUT_O),
    .pin_oe_n_o (HEAD_DRIVER_OUTPUT_OE_N_O)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // Every property samples on the shift clock; most sleep through reset

  ////////////////////////////////////////////////////////////////////////
  // Helper: run of back-to-back shifts
  // A full-word cascade window is too long to unroll as a repetition, so
  // the run of consecutive shift cycles is counted here instead. It stops
  // one short of a full register: with one more shift a whole word passed.
  localparam int unsigned RUN_W   = $clog2(thd_pkg::STAGES); // Counter width
  localparam int unsigned RUN_TOP = thd_pkg::STAGES - 1;     // Saturation point
  logic [RUN_W-1:0] run_r, run_nxt;                          // Consecutive shift count
  logic             run_full;                                // Run long enough for a word

  // Next run count: grow on shift, restart on a pause
  always_comb begin
    run_full = (run_r == RUN_W'(RUN_TOP));
    if (!SHIFT_EN_I) begin
      // A pause breaks the run
      run_nxt = RUN_W'(0);
    end else if (run_full) begin
      // Saturate, the window is already full
      run_nxt = run_r;
    end else begin
      // One more shift in the run
      run_nxt = run_r + RUN_W'(1);
    end
  end

  // Register the run count
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      // No shifts seen since reset
      run_r <= RUN_W'(0);
    end else begin
      // Take the next count
      run_r <= run_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shift register checks

  property p_shift_in;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      SHIFT_EN_I |=> shift_r[0] == $past(SERIAL_I);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("shift input lost");

  property p_shift_move;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      SHIFT_EN_I |=> shift_r[thd_pkg::STAGES-1:1] == $past(shift_r[thd_pkg::STAGES-2:0]);
  endproperty
  a_shift_move: assert property (p_shift_move) else $error("shift stages not moved");

  property p_shift_idle;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      !SHIFT_EN_I |=> $stable(shift_r);
  endproperty
  a_shift_idle: assert property (p_shift_idle) else $error("shift register moved idle");

  property p_reset_clear;
    @(posedge CLOCK_I)
      !RST_N_I |=> (shift_r == thd_pkg::CLEAR_VALUE) && (hold_r == thd_pkg::CLEAR_VALUE) && !SERIAL_O;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left data");

  ////////////////////////////////////////////////////////////////////////
  // Cascade output checks

  property p_cascade;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      (SHIFT_EN_I && run_full) |=> SERIAL_O == $past(SERIAL_I, thd_pkg::STAGES);
  endproperty
  a_cascade: assert property (p_cascade) else $error("cascade out wrong");

  property p_cascade_next;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      SHIFT_EN_I |=> SERIAL_O == $past(shift_r[thd_pkg::STAGES-2]);
  endproperty
  a_cascade_next: assert property (p_cascade_next) else $error("cascade step wrong");

  property p_serial_idle;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      !SHIFT_EN_I |=> $stable(SERIAL_O);
  endproperty
  a_serial_idle: assert property (p_serial_idle) else $error("cascade moved idle");

  ////////////////////////////////////////////////////////////////////////
  // Latch checks

  property p_latch;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      $fell(LATCH_STROBE_I) |=> hold_r == $past(shift_r);
  endproperty
  a_latch: assert property (p_latch) else $error("latch not captured");

  property p_hold;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      !$fell(LATCH_STROBE_I) |=> $stable(hold_r);
  endproperty
  a_hold: assert property (p_hold) else $error("latch changed");

  ////////////////////////////////////////////////////////////////////////
  // Driver checks

  property p_low_off;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      OUTPUT_ENABLE_ACTIVE_LOW_N_I |-> &HEAD_DRIVER_OUTPUT_OE_N_O;
  endproperty
  a_low_off: assert property (p_low_off) else $error("driven while low enable off");

  property p_high_off;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      !OUTPUT_ENABLE_ACTIVE_HIGH_I |-> &HEAD_DRIVER_OUTPUT_OE_N_O;
  endproperty
  a_high_off: assert property (p_high_off) else $error("driven while high enable off");

  property p_sink_only;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      HEAD_DRIVER_OUTPUT_O == '0;
  endproperty
  a_sink_only: assert property (p_sink_only) else $error("driver pulled high");

  property p_pass;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      (!OUTPUT_ENABLE_ACTIVE_LOW_N_I && OUTPUT_ENABLE_ACTIVE_HIGH_I)
        |-> HEAD_DRIVER_OUTPUT_OE_N_O == ~hold_r;
  endproperty
  a_pass: assert property (p_pass) else $error("driver not following latch");

  property p_sink_needs_bit;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      (~HEAD_DRIVER_OUTPUT_OE_N_O & ~hold_r) == '0;
  endproperty
  a_sink_needs_bit: assert property (p_sink_needs_bit) else $error("sink on clear bit");

  property p_oe_reset;
    @(posedge CLOCK_I)
      !RST_N_I |=> &HEAD_DRIVER_OUTPUT_OE_N_O;
  endproperty
  a_oe_reset: assert property (p_oe_reset) else $error("driver sinking after reset");
endmodule : thd_head_driver
`default_nettype wire

// ---- thd_pkg.sv ----
package thd_pkg;
  // Number of shift, latch and driver stages
  localparam int unsigned STAGES = 12;
  // Reset value of shift register and latch
  localparam logic [STAGES-1:0] CLEAR_VALUE = 12'h000;
  // Driven level of an open-drain output
  localparam logic SINK_LEVEL = 1'h0;
  // Strobe level at reset, idle high
  localparam logic STROBE_IDLE = 1'h1;
endpackage : thd_pkg

// ---- thd_printer_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// Printer controller: shifts words, then strobes the latch
module thd_printer_model (
  input  wire logic clk_i,
  output logic      shift_en_o,
  output logic      serial_o,
  output logic      strobe_o
);
  // Idle: no shift, strobe high
  initial begin
    shift_en_o = 1'h0;
    serial_o   = 1'h0;
    strobe_o   = 1'h1;
  end
  task automatic send(input logic [11:0] w);
    for (int i = 11; i >= 0; i--) begin
      @(negedge clk_i);
      shift_en_o = 1'h1;
      serial_o   = w[i];
    end
    @(negedge clk_i);
    shift_en_o = 1'h0;
    serial_o   = ~serial_o;
  endtask : send
  task automatic strobe();
    @(negedge clk_i);
    strobe_o = 1'h1;
    @(negedge clk_i);
    strobe_o = 1'h0;
  endtask : strobe
endmodule : thd_printer_model
`default_nettype wire
